// ==== rtl/resa_defines.svh ====
// Constants for the serial slave access block
`ifndef RESA_DEFINES_SVH
`define RESA_DEFINES_SVH

`define RESA_ARRAY_ID    4'hA
`define RESA_CCR_ID      4'hD
`define RESA_DEV_SEL     3'h7
`define RESA_ARRAY_PAGE  16'h0040
`define RESA_CCR_PAGE    16'h0008
`define RESA_ARRAY_DEPTH 32'h0000_0800
`define RESA_CCR_DEPTH   32'h0000_0040
`define RESA_ADDR_RESET  16'h0000
`define RESA_TWC_NS      32'h004C_4B40
`define RESA_CLK_MHZ     32'h0000_00C8
`define RESA_TWC_CYCLES  ((`RESA_TWC_NS * `RESA_CLK_MHZ) / 32'h0000_03E8)

`endif

// ==== rtl/resa_pkg.sv ====
// Types shared by the serial slave access block
package resa_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SLAVE,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA
  } resa_state_t;

endpackage

// ==== rtl/resa_core_if.sv ====
// Carrier between line conditioning, control and storage
`timescale 1ns/1ps
`default_nettype none
interface resa_core_if;
  logic        scl_rise;
  logic        scl_fall;
  logic        sda;
  logic        start;
  logic        stop;
  logic        wr_en;
  logic        wr_ccr;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic        commit;
  logic        abort;
  logic        rd_ccr;
  logic [15:0] rd_addr;
  logic [7:0]  rd_data;
  logic        busy;

  modport line_mp (output scl_rise, scl_fall, sda, start, stop);
  modport store_mp (input wr_en, wr_ccr, wr_addr, wr_data, commit, abort, rd_ccr, rd_addr,
                    output rd_data, busy);
endinterface
`default_nettype wire

// ==== rtl/resa_line_sync.sv ====
// Pin synchroniser with edge, start and stop detection
`timescale 1ns/1ps
`default_nettype none
module resa_line_sync (
  input  wire logic    i_clk,
  input  wire logic    i_rst_n,
  input  wire logic    i_ce,
  input  wire logic    i_scl,
  input  wire logic    i_sda,
  resa_core_if.line_mp lnk
);
  logic scl_s1;
  logic scl_s2;
  logic scl_d;
  logic sda_s1;
  logic sda_s2;
  logic sda_d;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else if (i_ce) begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  assign lnk.sda      = sda_s2;
  assign lnk.scl_rise = scl_s2 & ~scl_d;
  assign lnk.scl_fall = ~scl_s2 & scl_d;
  // Data moving while clock stays high
  assign lnk.start    = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign lnk.stop     = scl_s2 & scl_d & ~sda_d & sda_s2;

  AST_START_SHAPE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    lnk.start |-> !lnk.stop && $past(sda_s2) && !sda_s2)
    else $error("Start flagged without a falling data line");
endmodule
`default_nettype wire

// ==== rtl/resa_nv_store.sv ====
// Nonvolatile storage with page buffer and write cycle timer
`timescale 1ns/1ps
`default_nettype none
`include "resa_defines.svh"
module resa_nv_store #(
  parameter int unsigned TWC_CYCLES  = `RESA_TWC_CYCLES,
  parameter int unsigned ARRAY_DEPTH = `RESA_ARRAY_DEPTH,
  parameter int unsigned CCR_DEPTH   = `RESA_CCR_DEPTH,
  parameter int unsigned PAGE        = 32'(`RESA_ARRAY_PAGE)
) (
  input  wire logic     i_clk,
  input  wire logic     i_rst_n,
  input  wire logic     i_ce,
  resa_core_if.store_mp nv
);
  localparam int unsigned AW = $clog2(ARRAY_DEPTH);
  localparam int unsigned CW = $clog2(CCR_DEPTH);
  localparam int unsigned PW = $clog2(PAGE);

  logic [7:0]      array_mem [ARRAY_DEPTH];
  logic [7:0]      ccr_mem   [CCR_DEPTH];
  logic [7:0]      page_buf  [PAGE];
  logic [PAGE-1:0] page_vld;
  logic [15:0]     page_base;
  logic            page_ccr;
  logic [31:0]     busy_cnt;
  logic            busy;
  logic            done;

  assign done    = busy && (busy_cnt == 32'h0000_0001);
  assign nv.busy = busy;
  assign nv.rd_data = nv.rd_ccr ? ccr_mem[nv.rd_addr[CW-1:0]] : array_mem[nv.rd_addr[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy     <= 1'b0;
      busy_cnt <= 32'h0000_0000;
    end else if (i_ce) begin
      if (nv.commit) begin
        busy     <= 1'b1;
        busy_cnt <= TWC_CYCLES;
      end else if (busy) begin
        busy     <= !done;
        busy_cnt <= busy_cnt - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      page_vld  <= '0;
      page_base <= 16'h0000;
      page_ccr  <= 1'b0;
    end else if (i_ce) begin
      if (nv.abort || done) begin
        page_vld <= '0;
      end else if (nv.wr_en) begin
        page_vld[nv.wr_addr[PW-1:0]] <= 1'b1;
        page_base <= nv.wr_addr;
        page_ccr  <= nv.wr_ccr;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && nv.wr_en) begin
      page_buf[nv.wr_addr[PW-1:0]] <= nv.wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && done) begin
      for (int i = 0; i < PAGE; i++) begin
        if (page_vld[i] && page_ccr) begin
          ccr_mem[CW'(i)] <= page_buf[i];
        end else if (page_vld[i]) begin
          array_mem[{page_base[AW-1:PW], PW'(i)}] <= page_buf[i];
        end
      end
    end
  end

  AST_COMMIT_LEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && nv.commit) |=> busy && (busy_cnt == TWC_CYCLES))
    else $error("Write cycle did not start with its full length");
endmodule
`default_nettype wire

// ==== rtl/resa_top.sv ====
// Serial slave access control for clock chip EEPROM and control section
`timescale 1ns/1ps
`default_nettype none
`include "resa_defines.svh"
module resa_top
  import resa_pkg::*;
#(
  parameter int unsigned TWC_CYCLES  = `RESA_TWC_CYCLES,
  parameter int unsigned ARRAY_DEPTH = `RESA_ARRAY_DEPTH,
  parameter int unsigned CCR_DEPTH   = `RESA_CCR_DEPTH
) (
  input  wire logic I_CORE_CLK,
  input  wire logic I_RST_N,
  input  wire logic I_CE,
  input  wire logic I_SCL,
  input  wire logic I_SDA,
  input  wire logic I_WRITE_ENABLE_LATCH,
  output logic      O_SDA,
  output logic      O_SDA_OE,
  output logic      O_BUSY
);

  function automatic logic slave_match(input logic [7:0] b);
    return ((b[7:4] == `RESA_ARRAY_ID) || (b[7:4] == `RESA_CCR_ID)) &&
           (b[3:1] == `RESA_DEV_SEL);
  endfunction

  // Write increment inside the page
  function automatic logic [15:0] next_wr(input logic [15:0] a, input logic clock_control_section);
    logic [15:0] m;
    m = clock_control_section ? (`RESA_CCR_PAGE - 16'h0001) : (`RESA_ARRAY_PAGE - 16'h0001);
    return (a & ~m) | ((a + 16'h0001) & m);
  endfunction

  // Read increment over the whole section
  function automatic logic [15:0] next_rd(input logic [15:0] a, input logic clock_control_section);
    logic [15:0] last;
    last = clock_control_section ? 16'(CCR_DEPTH - 1) : 16'(ARRAY_DEPTH - 1);
    return (a >= last) ? 16'h0000 : a + 16'h0001;
  endfunction

  resa_core_if u_lnk ();

  resa_state_t state;
  logic [3:0]  bit_cnt;
  logic        ack_phase;
  logic        sda_drive;
  logic        slv_ok;
  logic        sel_ccr;
  logic        rd_mode;
  logic        got_byte;
  logic        master_ack;
  logic [7:0]  shreg;
  logic [7:0]  addr_hi;
  logic [15:0] addr_cnt;
  logic        active;
  logic        ev_bit;
  logic        ev_shift;
  logic        ev_ack_go;
  logic        ev_ack_end;
  logic        ev_ack_smp;
  logic        accept;
  logic        load_rd;
  logic        bus_reset;

  resa_line_sync u_sync (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_scl   (I_SCL),
    .i_sda   (I_SDA),
    .lnk     (u_lnk)
  );

  resa_nv_store #(
    .TWC_CYCLES  (TWC_CYCLES),
    .ARRAY_DEPTH (ARRAY_DEPTH),
    .CCR_DEPTH   (CCR_DEPTH),
    .PAGE        (32'(`RESA_ARRAY_PAGE))
  ) u_store (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .nv      (u_lnk)
  );

  assign active     = (state != ST_IDLE) && !u_lnk.busy;
  assign bus_reset  = u_lnk.busy || u_lnk.stop || u_lnk.start;

  assign ev_bit     = I_CE && active && u_lnk.scl_rise && !ack_phase && (bit_cnt < 4'h8);
  assign ev_shift   = I_CE && active && u_lnk.scl_fall && !ack_phase &&
                      (bit_cnt != 4'h0) && (bit_cnt < 4'h8);
  assign ev_ack_go  = I_CE && active && u_lnk.scl_fall && !ack_phase && (bit_cnt == 4'h8);
  assign ev_ack_end = I_CE && active && u_lnk.scl_fall && ack_phase;
  assign ev_ack_smp = I_CE && active && u_lnk.scl_rise && ack_phase;

  // first byte after read slave byte, next byte after master acknowledge
  assign load_rd = ((state == ST_SLAVE) && slv_ok && rd_mode) ||
                   ((state == ST_RDATA) && master_ack);

  // Acknowledge decision per byte kind
  always_comb begin
    case (state)
      ST_SLAVE:   accept = slave_match(shreg);
      ST_ADDR_HI,
      ST_ADDR_LO: accept = 1'b1;
      ST_WDATA:   accept = I_WRITE_ENABLE_LATCH;
      default:    accept = 1'b0;
    endcase
  end

  assign u_lnk.commit  = I_CE && u_lnk.stop && (state == ST_WDATA) && got_byte &&
                         (bit_cnt == 4'h1) && !ack_phase;
  assign u_lnk.abort   = I_CE && (u_lnk.stop || u_lnk.start) && !u_lnk.commit &&
                         (state != ST_IDLE);
  assign u_lnk.wr_en   = ev_ack_go && (state == ST_WDATA) && I_WRITE_ENABLE_LATCH;
  assign u_lnk.wr_addr = addr_cnt;
  assign u_lnk.wr_data = shreg;
  assign u_lnk.wr_ccr  = sel_ccr;
  assign u_lnk.rd_addr = addr_cnt;
  assign u_lnk.rd_ccr  = sel_ccr;

  // Transfer state
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      state <= ST_IDLE;
    end else if (I_CE) begin
      if (u_lnk.busy || u_lnk.stop) begin
        state <= ST_IDLE;
      end else if (u_lnk.start) begin
        state <= ST_SLAVE;
      end else if (ev_ack_end) begin
        case (state)
          ST_SLAVE: begin
            if (!slv_ok) begin
              state <= ST_IDLE;
            end else if (rd_mode) begin
              state <= ST_RDATA;
            end else begin
              state <= ST_ADDR_HI;
            end
          end
          ST_ADDR_HI: state <= ST_ADDR_LO;
          ST_ADDR_LO: state <= ST_WDATA;
          ST_RDATA:   state <= master_ack ? ST_RDATA : ST_IDLE;
          default:    state <= state;
        endcase
      end
    end
  end

  // Bit and acknowledge phase counting
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      bit_cnt   <= 4'h0;
      ack_phase <= 1'b0;
    end else if (I_CE) begin
      if (bus_reset) begin
        bit_cnt   <= 4'h0;
        ack_phase <= 1'b0;
      end else if (ev_bit) begin
        bit_cnt <= bit_cnt + 4'h1;
      end else if (ev_ack_go) begin
        ack_phase <= 1'b1;
      end else if (ev_ack_end) begin
        ack_phase <= 1'b0;
        bit_cnt   <= 4'h0;
      end
    end
  end

  // Shift register for both directions
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      shreg <= 8'h00;
    end else if (I_CE) begin
      if (ev_bit && (state != ST_RDATA)) begin
        shreg <= {shreg[6:0], u_lnk.sda};
      end else if (ev_shift && (state == ST_RDATA)) begin
        shreg <= {shreg[6:0], 1'b0};
      end else if (ev_ack_end && load_rd) begin
        shreg <= u_lnk.rd_data;
      end
    end
  end

  // Slave byte decode
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      slv_ok  <= 1'b0;
      sel_ccr <= 1'b0;
      rd_mode <= 1'b0;
    end else if (I_CE && ev_ack_go && (state == ST_SLAVE)) begin
      slv_ok <= accept;
      if (accept) begin
        sel_ccr <= (shreg[7:4] == `RESA_CCR_ID);
        rd_mode <= shreg[0];
      end
    end
  end

  // Master acknowledge sample
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      master_ack <= 1'b0;
    end else if (I_CE && ev_ack_smp) begin
      master_ack <= !u_lnk.sda;
    end
  end

  // Data line pull-down
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      sda_drive <= 1'b0;
    end else if (I_CE) begin
      if (bus_reset) begin
        sda_drive <= 1'b0;
      end else if (ev_ack_go) begin
        sda_drive <= accept;
      end else if (ev_shift && (state == ST_RDATA)) begin
        sda_drive <= !shreg[6];
      end else if (ev_ack_end) begin
        sda_drive <= load_rd ? !u_lnk.rd_data[7] : 1'b0;
      end
    end
  end

  // Full data byte plus acknowledge seen
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      got_byte <= 1'b0;
    end else if (I_CE) begin
      if (bus_reset) begin
        got_byte <= 1'b0;
      end else if (ev_ack_end && (state == ST_WDATA) && sda_drive) begin
        got_byte <= 1'b1;
      end
    end
  end

  // Address counter
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      addr_cnt <= `RESA_ADDR_RESET;
      addr_hi  <= 8'h00;
    end else if (I_CE && ev_ack_go) begin
      case (state)
        ST_ADDR_HI: addr_hi <= shreg;
        ST_ADDR_LO: addr_cnt <= {addr_hi, shreg};
        ST_WDATA: begin
          if (I_WRITE_ENABLE_LATCH) begin
            addr_cnt <= next_wr(addr_cnt, sel_ccr);
          end
        end
        ST_RDATA:   addr_cnt <= next_rd(addr_cnt, sel_ccr);
        default:    addr_hi <= addr_hi;
      endcase
    end
  end

  assign O_SDA    = 1'b0;
  assign O_SDA_OE = sda_drive;
  assign O_BUSY   = u_lnk.busy;

  AST_BUSY_QUIET: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    u_lnk.busy |-> !O_SDA_OE && (state == ST_IDLE))
    else $error("Bus answered during the write cycle");

  AST_POLL_NACK: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (u_lnk.busy && I_CE && u_lnk.start) |=> (state == ST_IDLE) && !O_SDA_OE)
    else $error("Start accepted while busy");

  AST_COMMIT_BUSY: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    u_lnk.commit |=> u_lnk.busy && (state == ST_IDLE))
    else $error("Stop after data did not start the write cycle");

  AST_ABORT_IDLE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (I_CE && u_lnk.stop && (state == ST_WDATA) && ((bit_cnt > 4'h1) || ack_phase))
    |=> !u_lnk.busy [*2])
    else $error("Partial byte started a write cycle");

  AST_PWRUP_ADDR: assert property (@(posedge I_CORE_CLK)
    !I_RST_N |=> (addr_cnt == 16'h0000) && (state == ST_IDLE))
    else $error("Address counter not cleared by reset");

  AST_SLAVE_ACK: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (ev_ack_go && (state == ST_SLAVE)) |=> (O_SDA_OE == slave_match($past(shreg))))
    else $error("Slave acknowledge disagrees with address compare");

  AST_SEL_BITS: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (ev_ack_go && (state == ST_SLAVE) && (shreg[3:1] != `RESA_DEV_SEL)) |=> !O_SDA_OE)
    else $error("Wrong select bits acknowledged");

  AST_READ_FIRST: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (ev_ack_end && (state == ST_SLAVE) && slv_ok && rd_mode)
    |=> (state == ST_RDATA) && (O_SDA_OE == !shreg[7]) && (bit_cnt == 4'h0))
    else $error("Read did not begin after slave acknowledge");

  AST_READ_INC: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (ev_ack_go && (state == ST_RDATA)) |=> (addr_cnt == next_rd($past(addr_cnt), sel_ccr)))
    else $error("Read address not advanced");

  AST_READ_WRAP: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (ev_ack_go && (state == ST_RDATA) && !sel_ccr && (addr_cnt == 16'(ARRAY_DEPTH - 1)))
    |=> (addr_cnt == 16'h0000))
    else $error("Read address did not roll over");

  AST_WRITE_WRAP: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    u_lnk.wr_en |=> (addr_cnt == next_wr($past(addr_cnt), sel_ccr)))
    else $error("Write address left its page");

  AST_WEL_NACK: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (ev_ack_go && (state == ST_WDATA) && !I_WRITE_ENABLE_LATCH) |=> !O_SDA_OE)
    else $error("Data acknowledged with latch cleared");

  AST_NACK_END: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (ev_ack_end && (state == ST_RDATA) && !master_ack) |=> (state == ST_IDLE) && !O_SDA_OE)
    else $error("Read continued after no acknowledge");

  AST_SEQ_NEXT: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (ev_ack_end && (state == ST_RDATA) && master_ack) |=> (state == ST_RDATA) &&
    (O_SDA_OE == !shreg[7]))
    else $error("Next read byte not presented");

  AST_SET_ADDR: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (I_CE && u_lnk.stop && (state == ST_WDATA) && !got_byte)
    |=> (state == ST_IDLE) && !u_lnk.busy && (addr_cnt == $past(addr_cnt)))
    else $error("Address-only stop misbehaved");

  AST_ADDR_LOAD: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (ev_ack_go && (state == ST_ADDR_LO)) |=> (addr_cnt == {addr_hi, $past(shreg)}))
    else $error("Word address not loaded");

  AST_DIR_BIT: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (ev_ack_end && (state == ST_SLAVE) && slv_ok) |=>
    (state == (rd_mode ? ST_RDATA : ST_ADDR_HI)))
    else $error("Direction bit not honoured");

endmodule
`default_nettype wire

// ==== dv/resa_master.sv ====
// Bus master model for the serial slave access bench
`timescale 1ns/1ps
`default_nettype none
module resa_master (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl = 1'b1,
  output logic      o_sda_oe = 1'b0
);
  task automatic hp();
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic start();
    o_sda_oe = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda_oe = 1'b1;
    hp();
    o_scl = 1'b0;
    hp();
  endtask
  task automatic stop();
    o_sda_oe = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda_oe = 1'b0;
    hp();
  endtask
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe = ~b;
    hp();
    o_scl = 1'b1;
    hp();
    s = i_sda;
    o_scl = 1'b0;
    hp();
  endtask
  task automatic xfer(input logic [7:0] b, input logic ma, output logic [7:0] s, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s[i]);
    bit_io(~ma, a);
    a = ~a;
  endtask
endmodule
`default_nettype wire

// ==== dv/resa_top_tb.sv ====
// Self-checking bench for the serial slave access block
`timescale 1ns/1ps
`default_nettype none
module resa_top_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       write_enable_latch = 1'b1;
  logic       scl, m_oe, d_oe, d_sda, busy, sda, ack;
  logic [7:0] r;
  int         n_errors = 0;
  int         n_tests = 0;
  always #2.5 clk = ~clk;
  // Pull-up unless a side pulls low
  assign sda = (d_oe ? d_sda : 1'b1) & ~m_oe;
  resa_top #(.TWC_CYCLES(300)) dut (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_SCL(scl), .I_SDA(sda),
    .I_WRITE_ENABLE_LATCH(write_enable_latch), .O_SDA(d_sda), .O_SDA_OE(d_oe), .O_BUSY(busy)
  );
  resa_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tx(input logic [7:0] b, input logic ea);
    m.xfer(b, 1'b0, r, ack);
    chk({7'h0, ack}, {7'h0, ea}, "ack");
  endtask
  task automatic rx(input logic last, input logic [7:0] e);
    m.xfer(8'hFF, ~last, r, ack);
    chk(r, e, "data");
  endtask
  task automatic addr(input logic [7:0] sb, input logic [15:0] a);
    m.start();
    tx(sb, 1'b1);
    tx(a[15:8], 1'b1);
    tx(a[7:0], 1'b1);
  endtask
  task automatic settle(input logic eb);
    int k;
    for (k = 0; k < 20 && busy !== 1'b1; k++)
      @(negedge clk);
    chk({7'h0, busy}, {7'h0, eb}, "busy");
    for (k = 0; k < 600 && busy !== 1'b0; k++)
      @(negedge clk);
    @(posedge clk);
    #1;
  endtask
  task automatic t_page();
    addr(8'hAE, 16'h0000);
    for (int i = 0; i < 66; i++)
      tx(8'h10 + 8'(i), 1'b1);
    m.stop();
    settle(1'b1);
    addr(8'hAE, 16'h0000);
    m.start();
    tx(8'hAF, 1'b1);
    for (int i = 0; i < 64; i++)
      rx(i == 63, (i < 2) ? 8'h50 + 8'(i) : 8'h10 + 8'(i));
    m.stop();
    $display("t_page done");
  endtask
  task automatic t_ccr();
    addr(8'hDE, 16'h0000);
    tx(8'h5A, 1'b1);
    m.stop();
    settle(1'b1);
    addr(8'hDE, 16'h003C);
    for (int i = 0; i < 8; i++)
      tx(8'hC0 + 8'(i), 1'b1);
    m.stop();
    settle(1'b1);
    addr(8'hDE, 16'h003B);
    m.stop();
    settle(1'b0);
    m.start();
    tx(8'hDF, 1'b1);
    for (int i = 0; i < 6; i++)
      rx(i == 5, (i == 0) ? 8'hC7 : (i < 5) ? 8'hBF + 8'(i) : 8'h5A);
    m.stop();
    $display("t_ccr done");
  endtask
  task automatic t_abort();
    addr(8'hAE, 16'h0002);
    for (int i = 0; i < 4; i++)
      m.bit_io(1'b0, r[i]);
    m.stop();
    settle(1'b0);
    write_enable_latch = 1'b0;
    addr(8'hAE, 16'h0003);
    tx(8'hEE, 1'b0);
    m.stop();
    settle(1'b0);
    write_enable_latch = 1'b1;
    addr(8'hAE, 16'h0002);
    m.start();
    tx(8'hAF, 1'b1);
    rx(1'b0, 8'h12);
    rx(1'b1, 8'h13);
    m.stop();
    $display("t_abort done");
  endtask
  task automatic t_poll();
    addr(8'hAE, 16'h0004);
    tx(8'h77, 1'b1);
    m.stop();
    m.start();
    tx(8'hAE, 1'b0);
    m.stop();
    settle(1'b1);
    m.start();
    tx(8'hAE, 1'b1);
    m.stop();
    settle(1'b0);
    $display("t_poll done");
  endtask
  task automatic t_match();
    logic [7:0] bad [5] = '{8'hA6, 8'hAC, 8'hBE, 8'h5E, 8'hDA};
    for (int i = 0; i < 5; i++) begin
      m.start();
      tx(bad[i], 1'b0);
      m.stop();
    end
    $display("t_match done");
  endtask
  task automatic t_wrap();
    addr(8'hAE, 16'h07FF);
    tx(8'h3C, 1'b1);
    m.stop();
    settle(1'b1);
    addr(8'hAE, 16'h07FF);
    m.start();
    tx(8'hAF, 1'b1);
    rx(1'b0, 8'h3C);
    rx(1'b1, 8'h50);
    m.stop();
    $display("t_wrap done");
  endtask
  task automatic t_reset();
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk({5'h0, d_sda, d_oe, busy}, 8'h00, "reset outputs");
    rst_n = 1'b1;
    m.start();
    tx(8'hAF, 1'b1);
    rx(1'b1, 8'h50);
    chk({7'h0, d_oe}, 8'h00, "released");
    m.stop();
    $display("t_reset done");
  endtask
  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_page();
    t_ccr();
    t_abort();
    t_poll();
    t_match();
    t_wrap();
    t_reset();
    tally_and_finish();
  end
  initial begin
    #400us;
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
